// File: core/isu_consts.svh
/*
 Offsets, field positions, reset values and compare masks of the
 integer subtract, trap and exclusive-or unit.
 Assumes byte addresses on an 8-bit APB address, one word per register.
*/
`ifndef ISU_CONSTS_SVH
`define ISU_CONSTS_SVH

`define ADDR_CTRL 8'h00
`define ADDR_LEFT 8'h04
`define ADDR_RIGHT 8'h08
`define ADDR_VALUE 8'h0C
`define ADDR_IMM 8'h10
`define ADDR_MASK 8'h14
`define ADDR_RESULT 8'h18
`define ADDR_FLAGS 8'h1C
`define ADDR_STATUS 8'h20
`define ADDR_IRQ_STAT 8'h24
`define ADDR_IRQ_EN 8'h28
`define ADDR_IRQ_CLR 8'h2C

`define CTRL_RC 4
`define CTRL_OE 5
`define FL_CA 0
`define FL_OV 1
`define FL_SO 2
`define FL_CR_LSB 4
`define IRQ_SYNC 0
`define IRQ_TRAP 1
`define IRQ_W 2

`define RST_WORD 32'h0000_0000
`define ALL_ONES 32'hFFFF_FFFF
`define TO_NEVER 5'h00
`define TO_EQ 5'h04
`define TO_LT 5'h10

`endif

// File: core/isu_pkg.sv
/*
 Types of the integer subtract, trap and exclusive-or unit.
 Needs no constants header; the op and state codes are given here.
*/
package isu_pkg;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_SUBFIC = 4'h1,
        OP_SUBFME = 4'h2,
        OP_SUBFZE = 4'h3,
        OP_SYNC = 4'h4,
        OP_TW = 4'h5,
        OP_TWI = 4'h6,
        OP_XOR = 4'h7,
        OP_XORI = 4'h8,
        OP_XORIS = 4'h9
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DRAIN = 2'b10
    } state_t;

    typedef struct packed {
        logic [31:0] left;
        logic [31:0] right;
        logic [31:0] value;
        logic [15:0] imm;
        logic [4:0] mask;
        logic carry;
    } alu_in_t;

    typedef struct packed {
        logic [31:0] sum;
        logic carry;
        logic ovf;
        logic trap;
        logic [31:0] xres;
    } alu_out_t;

    typedef struct packed {
        logic [3:0] cr0;
        logic sticky;
        logic wrap;
        logic carry;
    } flags_t;

endpackage

// File: core/isu_alu.sv
/*
 Combinational datapath: subtract sums, trap compare, exclusive-or.
 Assumes operands held stable by the register block around it.
*/
`timescale 1ns/10ps
`include "isu_consts.svh"
module isu_alu (
    // Operation and operands
    input wire isu_pkg::op_t op,
    input wire isu_pkg::alu_in_t din,
    // Results
    output isu_pkg::alu_out_t dout
);
    logic [31:0] signed_imm16;
    logic [31:0] addend;
    logic cin;
    logic [32:0] s;
    logic [31:0] cmpb;
    logic lt, gt, eq, ltu, gtu;

    always_comb begin
        signed_imm16 = {{16{din.imm[15]}}, din.imm};
        unique case (op)
            isu_pkg::OP_SUBFIC: begin
                addend = signed_imm16;
                cin = 1'b1;
            end
            isu_pkg::OP_SUBFME: begin
                addend = `ALL_ONES;
                cin = din.carry;
            end
            default: begin
                addend = `RST_WORD;
                cin = din.carry;
            end
        endcase
        // Carry is bit 32 of the three-operand sum
        s = {1'b0, ~din.left} + {1'b0, addend} + {32'h0000_0000, cin};
        dout.sum = s[31:0];
        dout.carry = s[32];
        dout.ovf = (~din.left[31] == addend[31]) && (s[31] != ~din.left[31]);
        // Immediate form compares against the sign-extended field
        cmpb = (op == isu_pkg::OP_TWI) ? signed_imm16 : din.right;
        lt = $signed(din.left) < $signed(cmpb);
        gt = $signed(din.left) > $signed(cmpb);
        eq = din.left == cmpb;
        ltu = din.left < cmpb;
        gtu = din.left > cmpb;
        // Mask MSB is the first condition, so 16 is less-than
        dout.trap = |(din.mask & {lt, gt, eq, ltu, gtu});
        unique case (op)
            isu_pkg::OP_XORI: dout.xres = din.value ^ {16'h0000, din.imm};
            isu_pkg::OP_XORIS: dout.xres = din.value ^ {din.imm, 16'h0000};
            default: dout.xres = din.value ^ din.right;
        endcase
    end

endmodule

// File: core/integer_subtract_trap_xor_unit.sv
/*
 Integer subtract, trap-on-compare and exclusive-or unit with an
 ordering barrier, reached over APB.
 Assumes the sequencer reports in-flight and memory completion on
 pclk, and that a CTRL write issues one operation.
*/
// Overview of operation
// - Immediate subtract: not-left plus immediate plus one
// - Minus-one form: not-left plus carry minus one
// - Zero form: not-left plus carry
// - Record bit updates condition field from result on minus-one, zero and register xor forms
// - Overflow enable sets wrap and sticky flags on minus-one and zero forms
// - Barrier holds later issue until earlier complete
// - Barrier finishes after external accesses performed
// - Register trap compares with five masked conditions
// - Any true masked condition raises trap
// - Immediate trap compares with sign-extended immediate
// - Mask encodings: eq 4, lt 16, ne 24
// - Register xor writes into left register
// - Xor immediate, zero upper half, no flags
// - Xor shifted immediate, zero lower half, no flags
`timescale 1ns/10ps
`include "isu_consts.svh"
module integer_subtract_trap_xor_unit (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sequencer status
    input wire logic inflight_empty,
    input wire logic mem_performed,
    // Exception and interrupt
    output logic trap_req,
    output logic irq
);

    logic [31:0] left_r, left_nxt;
    logic [31:0] right_r, right_nxt;
    logic [31:0] value_r, value_nxt;
    logic [31:0] result_r, result_nxt;
    logic [15:0] imm_r, imm_nxt;
    logic [4:0] mask_r, mask_nxt;
    isu_pkg::flags_t flags_r, flags_nxt;
    isu_pkg::state_t state_r, state_nxt;
    logic [`IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
    logic [`IRQ_W-1:0] irq_en_r, irq_en_nxt;
    logic [`IRQ_W-1:0] irq_set;
    logic trap_r, trap_nxt;
    logic [31:0] prdata_r, prdata_nxt;

    logic access, wr_ctrl, stall, wr_ok, issue, mapped;
    logic cur_rc, cur_oe, sub_ext, new_sticky;
    isu_pkg::op_t cur_op;
    isu_pkg::alu_in_t alu_in;
    isu_pkg::alu_out_t alu_out;

    // Bus decode
    assign access = psel && penable;
    assign wr_ctrl = access && pwrite && (paddr == `ADDR_CTRL);
    // Later operations wait at the bus while the barrier drains
    assign stall = wr_ctrl && (state_r == isu_pkg::ST_DRAIN);
    assign pready = !stall;
    assign wr_ok = access && pwrite && !stall;
    assign issue = wr_ctrl && !stall;
    assign cur_op = isu_pkg::op_t'(pwdata[3:0]);
    assign cur_rc = pwdata[`CTRL_RC];
    assign cur_oe = pwdata[`CTRL_OE];
    assign sub_ext = (cur_op == isu_pkg::OP_SUBFME) || (cur_op == isu_pkg::OP_SUBFZE);

    always_comb begin
        unique case (paddr)
            `ADDR_CTRL, `ADDR_LEFT, `ADDR_RIGHT, `ADDR_VALUE,
            `ADDR_IMM, `ADDR_MASK, `ADDR_RESULT, `ADDR_FLAGS,
            `ADDR_STATUS, `ADDR_IRQ_STAT, `ADDR_IRQ_EN, `ADDR_IRQ_CLR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = access && !mapped;

    assign alu_in = '{left: left_r, right: right_r, value: value_r,
                      imm: imm_r, mask: mask_r, carry: flags_r.carry};

    isu_alu u_alu (
        .op(cur_op),
        .din(alu_in),
        .dout(alu_out)
    );

    // Operand file, result and flags
    always_comb begin
        left_nxt = left_r;
        right_nxt = right_r;
        value_nxt = value_r;
        imm_nxt = imm_r;
        mask_nxt = mask_r;
        result_nxt = result_r;
        flags_nxt = flags_r;
        new_sticky = flags_r.sticky;
        if (wr_ok && mapped) begin
            unique case (paddr)
                `ADDR_LEFT: left_nxt = pwdata;
                `ADDR_RIGHT: right_nxt = pwdata;
                `ADDR_VALUE: value_nxt = pwdata;
                `ADDR_IMM: imm_nxt = pwdata[15:0];
                `ADDR_MASK: mask_nxt = pwdata[4:0];
                `ADDR_FLAGS: begin
                    flags_nxt.carry = pwdata[`FL_CA];
                    flags_nxt.wrap = pwdata[`FL_OV];
                    flags_nxt.sticky = pwdata[`FL_SO];
                    flags_nxt.cr0 = pwdata[`FL_CR_LSB+3:`FL_CR_LSB];
                end
                default: ;
            endcase
        end
        if (issue) begin
            unique case (cur_op)
                isu_pkg::OP_SUBFIC: begin
                    result_nxt = alu_out.sum;
                    flags_nxt.carry = alu_out.carry;
                end
                isu_pkg::OP_SUBFME, isu_pkg::OP_SUBFZE: begin
                    result_nxt = alu_out.sum;
                    flags_nxt.carry = alu_out.carry;
                    if (cur_oe) begin
                        // Wrap follows this result; sticky only ever sets
                        flags_nxt.wrap = alu_out.ovf;
                        new_sticky = flags_r.sticky | alu_out.ovf;
                        flags_nxt.sticky = new_sticky;
                    end
                    if (cur_rc) begin
                        flags_nxt.cr0 = {alu_out.sum[31],
                                         !alu_out.sum[31] && (alu_out.sum != `RST_WORD),
                                         alu_out.sum == `RST_WORD, new_sticky};
                    end
                end
                isu_pkg::OP_XOR: begin
                    left_nxt = alu_out.xres;
                    if (cur_rc) begin
                        flags_nxt.cr0 = {alu_out.xres[31],
                                         !alu_out.xres[31] && (alu_out.xres != `RST_WORD),
                                         alu_out.xres == `RST_WORD, flags_r.sticky};
                    end
                end
                isu_pkg::OP_XORI, isu_pkg::OP_XORIS: begin
                    left_nxt = alu_out.xres;
                end
                // Traps and the barrier leave the operand file alone
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_r <= `RST_WORD;
            right_r <= `RST_WORD;
            value_r <= `RST_WORD;
            result_r <= `RST_WORD;
            imm_r <= 16'h0000;
            mask_r <= `TO_NEVER;
            flags_r <= '0;
        end else begin
            left_r <= left_nxt;
            right_r <= right_nxt;
            value_r <= value_nxt;
            result_r <= result_nxt;
            imm_r <= imm_nxt;
            mask_r <= mask_nxt;
            flags_r <= flags_nxt;
        end
    end

    // Barrier, trap, interrupts and read data
    always_comb begin
        state_nxt = state_r;
        irq_set = '0;
        unique case (state_r)
            isu_pkg::ST_IDLE: begin
                if (issue && cur_op == isu_pkg::OP_SYNC) begin
                    state_nxt = isu_pkg::ST_DRAIN;
                end
            end
            isu_pkg::ST_DRAIN: begin
                // Done only once memory traffic is performed
                if (inflight_empty && mem_performed) begin
                    state_nxt = isu_pkg::ST_IDLE;
                    irq_set[`IRQ_SYNC] = 1'b1;
                end
            end
        endcase
        trap_nxt = issue && alu_out.trap &&
                   (cur_op == isu_pkg::OP_TW || cur_op == isu_pkg::OP_TWI);
        irq_set[`IRQ_TRAP] = trap_nxt;
        irq_stat_nxt = irq_stat_r;
        if (wr_ok && paddr == `ADDR_IRQ_CLR) begin
            irq_stat_nxt = irq_stat_r & ~pwdata[`IRQ_W-1:0];
        end
        // A new event wins over a clear in the same cycle
        irq_stat_nxt = irq_stat_nxt | irq_set;
        irq_en_nxt = irq_en_r;
        if (wr_ok && paddr == `ADDR_IRQ_EN) begin
            irq_en_nxt = pwdata[`IRQ_W-1:0];
        end
        // Read data is captured in the setup cycle so it comes from a flop
        prdata_nxt = prdata_r;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `ADDR_LEFT: prdata_nxt = left_r;
                `ADDR_RIGHT: prdata_nxt = right_r;
                `ADDR_VALUE: prdata_nxt = value_r;
                `ADDR_IMM: prdata_nxt = {16'h0000, imm_r};
                `ADDR_MASK: prdata_nxt = {27'h0000000, mask_r};
                `ADDR_RESULT: prdata_nxt = result_r;
                `ADDR_FLAGS: prdata_nxt = {24'h000000, flags_r.cr0, 1'b0,
                                           flags_r.sticky, flags_r.wrap, flags_r.carry};
                `ADDR_STATUS: prdata_nxt = {31'h00000000, state_r == isu_pkg::ST_DRAIN};
                `ADDR_IRQ_STAT: prdata_nxt = {30'h00000000, irq_stat_r};
                `ADDR_IRQ_EN: prdata_nxt = {30'h00000000, irq_en_r};
                default: prdata_nxt = `RST_WORD;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= isu_pkg::ST_IDLE;
            trap_r <= 1'b0;
            irq_stat_r <= '0;
            irq_en_r <= '0;
            prdata_r <= `RST_WORD;
        end else begin
            state_r <= state_nxt;
            trap_r <= trap_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;
    assign trap_req = trap_r;
    assign irq = |(irq_stat_r & irq_en_r);

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [32:0] ref_ic;
    assign ref_ic = {1'b0, ~left_r} + {1'b0, {16{imm_r[15]}}, imm_r} + 33'h000000001;

    sequence s_issue(isu_pkg::op_t o);
        issue && cur_op == o;
    endsequence

    sequence s_drain_done;
        state_r == isu_pkg::ST_DRAIN ##1 state_r == isu_pkg::ST_IDLE;
    endsequence

    a_subfic_carry: assert property (
        s_issue(isu_pkg::OP_SUBFIC) |=>
            result_r == $past(ref_ic[31:0]) && flags_r.carry == $past(ref_ic[32]))
        else $error("immediate subtract result or carry wrong");

    a_subfme_value: assert property (
        s_issue(isu_pkg::OP_SUBFME) |=>
            result_r == $past(~left_r + {31'h00000000, flags_r.carry} - 32'h00000001))
        else $error("minus-one subtract result wrong");

    a_subfze_value: assert property (
        s_issue(isu_pkg::OP_SUBFZE) |=>
            result_r == $past(~left_r + {31'h00000000, flags_r.carry}))
        else $error("zero subtract result wrong");

    a_subfze_carry: assert property (
        s_issue(isu_pkg::OP_SUBFZE) |=>
            flags_r.carry == $past(left_r == `RST_WORD && flags_r.carry))
        else $error("zero subtract carry wrong");

    a_sticky_keep: assert property (
        issue && sub_ext && cur_oe && flags_r.sticky |=> flags_r.sticky)
        else $error("sticky summary flag was cleared");

    a_trap_pulse: assert property (
        trap_req |=> !trap_req)
        else $error("trap request longer than one cycle");

    a_cr0_eq_bit: assert property (
        issue && sub_ext && cur_rc |=> flags_r.cr0[1] == (result_r == `RST_WORD))
        else $error("equal bit does not match result");

    a_wrap_hold: assert property (
        issue && sub_ext && !cur_oe |=> $stable(flags_r.wrap) && $stable(flags_r.sticky))
        else $error("wrap or sticky changed without enable");

    a_sync_stall: assert property (
        state_r == isu_pkg::ST_DRAIN && wr_ctrl |=> $stable(result_r) && $stable(left_r))
        else $error("operation taken during barrier");

    a_sync_release: assert property (
        s_drain_done |-> $past(inflight_empty && mem_performed))
        else $error("barrier ended before memory performed");

    a_trap_eq_fire: assert property (
        s_issue(isu_pkg::OP_TW) && mask_r == `TO_EQ && left_r == right_r |=> trap_req)
        else $error("equal trap missed");

    a_trap_lt_imm: assert property (
        s_issue(isu_pkg::OP_TWI) && mask_r == `TO_LT &&
            $signed(left_r) < $signed({{16{imm_r[15]}}, imm_r}) |=> trap_req)
        else $error("immediate less-than trap missed");

    a_trap_quiet: assert property (
        issue && (cur_op == isu_pkg::OP_TW || cur_op == isu_pkg::OP_TWI) &&
            mask_r == `TO_NEVER |=> !trap_req && $stable(left_r) && $stable(result_r))
        else $error("trap with empty mask or registers changed");

    a_xor_reg: assert property (
        s_issue(isu_pkg::OP_XOR) |=> left_r == $past(value_r ^ right_r))
        else $error("register xor wrong");

    a_xori_low: assert property (
        s_issue(isu_pkg::OP_XORI) |=>
            left_r == $past(value_r ^ {16'h0000, imm_r}) && $stable(flags_r))
        else $error("xor immediate wrong or flags changed");

    a_xoris_high: assert property (
        s_issue(isu_pkg::OP_XORIS) |=>
            left_r == $past(value_r ^ {imm_r, 16'h0000}) && $stable(flags_r))
        else $error("xor shifted immediate wrong or flags changed");

    a_xor_record: assert property (
        s_issue(isu_pkg::OP_XOR) && cur_rc |=>
            flags_r.cr0[0] == $past(flags_r.sticky) && flags_r.cr0[3] == left_r[31])
        else $error("xor record field wrong");

endmodule

// File: verification/seq_partner.sv
/*
 Sequencer stand-in: reports when earlier instructions and external
 memory accesses are complete.
 Assumes the bench pulses start just before it issues a barrier.
*/
`timescale 1ns/10ps
module seq_partner (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench control
    input wire logic start,
    input wire logic [4:0] delay,
    // Status to the unit
    output logic inflight_empty,
    output logic mem_performed
);
    logic [4:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 5'h00;
        end else if (start) begin
            cnt_r <= delay;
        end else if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
        end
    end

    // Instructions retire before memory drains, so a barrier must wait for both
    assign inflight_empty = (cnt_r < 5'h03);
    assign mem_performed = (cnt_r == 5'h00);
endmodule

// File: verification/tb_top.sv
/*
 Self-checking bench for the subtract, trap and exclusive-or unit.
 Assumes the APB map of the constants header and a slave that answers within 60 cycles.
*/
`timescale 1ns/10ps
`include "isu_consts.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, trap_req, irq, start;
    logic inflight_empty, mem_performed, rdy_q, err_q, mp_q, ctrl_mp;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_q, q;
    logic [4:0] delay;
    int err_total = 0;
    int n_compared = 0;
    int ctrl_n;
    logic [31:0] m_left, m_right, m_value, m_result, wl[4];
    logic [15:0] m_imm;
    logic [4:0] m_mask, masks[9];
    logic m_ca, m_ov, m_so;
    logic [3:0] m_cr, ops[7];
    logic [1:0] m_irq;

    integer_subtract_trap_xor_unit i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .inflight_empty(inflight_empty),
        .mem_performed(mem_performed), .trap_req(trap_req), .irq(irq));
    seq_partner i_seq (.pclk(pclk), .presetn(presetn), .start(start), .delay(delay),
        .inflight_empty(inflight_empty), .mem_performed(mem_performed));

    always #10 pclk = ~pclk;
    // Inputs move only after rising edges, so this is the value at the next edge
    always @(negedge pclk) begin
        rdy_q = pready;
        err_q = pslverr;
        rd_q = prdata;
        mp_q = mem_performed;
    end

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (!rdy_q && n < 60);
        if (!rdy_q) `CHK(rdy_q, 1'b1)
        q = rd_q;
        // Only the operation write is remembered, later reads must not hide it
        if (w && a == `ADDR_CTRL) begin
            ctrl_n = n;
            ctrl_mp = mp_q;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask

    function automatic logic [31:0] flags_word();
        return {24'h0, m_cr, 1'b0, m_so, m_ov, m_ca};
    endfunction

    task automatic set_regs(input logic [31:0] l, r, v, input logic [15:0] im,
                            input logic [4:0] mk, input logic [7:0] f);
        m_left = l;
        m_right = r;
        m_value = v;
        m_imm = im;
        m_mask = mk;
        {m_cr, m_so, m_ov, m_ca} = {f[7:4], f[2:0]};
        apb(1'b1, `ADDR_LEFT, l);
        apb(1'b1, `ADDR_RIGHT, r);
        apb(1'b1, `ADDR_VALUE, v);
        apb(1'b1, `ADDR_IMM, {16'h0, im});
        apb(1'b1, `ADDR_MASK, {27'h0, mk});
        apb(1'b1, `ADDR_FLAGS, flags_word());
    endtask

    task automatic issue(input logic [3:0] op, input logic rc, input logic oe);
        logic [32:0] s;
        logic [31:0] a, b, c;
        logic t;
        a = ~m_left;
        b = (op == 4'h1) ? {{16{m_imm[15]}}, m_imm} : (op == 4'h2) ? `ALL_ONES : 32'h0;
        s = {1'b0, a} + {1'b0, b} + ((op == 4'h1) ? 33'h1 : {32'h0, m_ca});
        c = (op == 4'h5) ? m_right : {{16{m_imm[15]}}, m_imm};
        t = (op == 4'h5 || op == 4'h6) && |(m_mask & {$signed(m_left) < $signed(c),
            $signed(m_left) > $signed(c), m_left == c, m_left < c, m_left > c});
        if (op >= 4'h1 && op <= 4'h3) begin
            m_result = s[31:0];
            m_ca = s[32];
            if (op != 4'h1 && oe) begin
                m_ov = (a[31] == b[31]) && (s[31] != a[31]);
                m_so = m_so | m_ov;
            end
            if (op != 4'h1 && rc) m_cr = {s[31], !s[31] && s[31:0] != 0, s[31:0] == 0, m_so};
        end
        if (op == 4'h7) m_left = m_value ^ m_right;
        if (op == 4'h7 && rc) m_cr = {m_left[31], !m_left[31] && m_left != 0, m_left == 0, m_so};
        if (op == 4'h8) m_left = m_value ^ {16'h0, m_imm};
        if (op == 4'h9) m_left = m_value ^ {m_imm, 16'h0};
        if (op == 4'h4) m_irq[0] = 1'b1;
        if (t) m_irq[1] = 1'b1;
        apb(1'b1, `ADDR_CTRL, {26'h0, oe, rc, op});
        #1;
        `CHK(trap_req, t)
        rd_chk(`ADDR_RESULT, m_result);
        rd_chk(`ADDR_LEFT, m_left);
        rd_chk(`ADDR_FLAGS, flags_word());
    endtask

    initial begin
        #1_000_000;
        err_total++;
        finish_test();
    end

    initial begin
        {psel, penable, pwrite, start, paddr, pwdata, delay} = '0;
        {m_left, m_right, m_value, m_result, m_imm, m_mask} = '0;
        {m_ca, m_ov, m_so, m_cr, m_irq} = '0;
        wl = '{32'h7FFF_FFFF, 32'h8000_0000, 32'h0, `ALL_ONES};
        ops = '{4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'hA};
        masks = '{5'd4, 5'd24, 5'd16, 5'd8, 5'd2, 5'd1, 5'd12, 5'd31, `TO_NEVER};
        void'($urandom(32'h2a91));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`ADDR_FLAGS, `RST_WORD);
        apb(1'b0, 8'h30, 32'h0);
        `CHK({err_q, q}, 33'h1_0000_0000)
        for (int i = 0; i < 40; i++) begin
            set_regs((i < 4) ? wl[i] : $urandom, $urandom, $urandom, $urandom, 5'h0,
                (i < 4) ? {7'h0, i[0]} : $urandom);
            foreach (ops[k]) issue(ops[k], $urandom, $urandom);
        end
        foreach (masks[i]) begin
            for (int k = 0; k < 4; k++) begin
                m_imm = $urandom;
                m_right = (k == 0) ? {{16{m_imm[15]}}, m_imm} : $urandom;
                set_regs((k == 0) ? m_right : $urandom, m_right, $urandom, m_imm, masks[i],
                    $urandom);
                issue(4'h5, 1'b0, 1'b0);
                issue(4'h6, 1'b0, 1'b0);
            end
        end
        rd_chk(`ADDR_IRQ_STAT, {30'h0, m_irq});
        #1;
        `CHK(irq, 1'b0)
        apb(1'b1, `ADDR_IRQ_EN, 32'h2);
        #1;
        `CHK(irq, m_irq[1])
        apb(1'b1, `ADDR_IRQ_CLR, 32'h2);
        #1;
        `CHK(irq, 1'b0)
        m_irq = 2'b00;
        apb(1'b1, `ADDR_IRQ_EN, 32'h1);
        @(posedge pclk);
        start <= 1'b1;
        // Drain must outlast the three readbacks and the status read
        delay <= 5'h14;
        @(posedge pclk);
        start <= 1'b0;
        issue(4'h4, 1'b0, 1'b0);
        rd_chk(`ADDR_STATUS, 32'h1);
        issue(4'h7, 1'b1, 1'b0);
        `CHK(ctrl_n > 1 && ctrl_mp, 1'b1)
        rd_chk(`ADDR_IRQ_STAT, 32'h1);
        #1;
        `CHK(irq, 1'b1)
        apb(1'b1, `ADDR_IRQ_CLR, 32'h1);
        delay <= 5'h00;
        issue(4'h4, 1'b0, 1'b0);
        issue(4'h8, 1'b0, 1'b0);
        rd_chk(`ADDR_STATUS, 32'h0);
        finish_test();
    end
endmodule
